// ===== hdl/ect_core_timing.sv
`timescale 1ns/1ps

// Behaviour
// - Opcodes decode to the classic encoding; only timing differs.
// - Every duration is counted in system clocks, never machine cycles.
// - Most instructions take as many cycles as program bytes.
// - Untaken conditional branch finishes one cycle earlier than taken.
// - External data write can instead program or erase on-chip flash.
// - Add, add-carry, subtract: register 1/1, direct/immediate 2/2, @ 1/2.
// - Inc/dec A or register 1, direct/indirect 2; pointer 1, mul 4, div 8.
// - Logic into A 1 or 2 cycles; into direct 2/2 or 3/3.
// - Clear of A or carry, rotates, swap 1/1; complement of A 1 byte 2 cycles.
// - Direct-to-direct and immediate-to-direct moves take 3 bytes, 3.
// - Moves into indirect RAM take 2 cycles, from A 1 byte; indirect to direct 2/2.
// - Loading 16-bit data pointer with immediate takes 3 bytes, 3 cycles.
// - Code byte reads take 1 byte, 3 cycles; A plus pointer or PC.
// - External data reads and writes take 1 byte, 3 cycles.
// - Push and pop of a direct byte take 2 bytes, 2 cycles.
// - Exchange: register 1, direct 2/2, indirect and low nibble 1/2.
// - Relative offset is signed 8-bit, added to next instruction address.
// - Direct address 00-7F is data RAM, 80-FF special registers.
// - Spare opcode A5 executes exactly as a no-operation.
module ect_core_timing
  import ect_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  input  wire logic        i_issue,
  input  wire logic [7:0]  i_opcode,
  input  wire logic        i_taken,
  input  wire logic [15:0] i_pc_next,
  input  wire logic [7:0]  i_rel,
  input  wire logic [7:0]  i_direct,
  input  wire logic [7:0]  i_acc,
  input  wire logic [7:0]  i_ri,
  input  wire logic [15:0] i_data_pointer_16,
  input  wire logic        i_flash_wr_en,
  input  wire logic        i_flash_erase,
  output logic             o_ready,
  output logic             o_busy,
  output logic             o_done,
  output logic [1:0]       o_len,
  output logic [3:0]       o_cycles,
  output logic             o_cond,
  output logic             o_external_data_space_rd,
  output logic             o_external_data_space_wr,
  output logic             o_flash_wr,
  output logic             o_flash_erase,
  output logic             o_code_rd,
  output logic [15:0]      o_addr,
  output logic [15:0]      o_target,
  output logic             o_dir_sfr
);

  ect_state_t st;
  ect_state_t next_st;

  // Map the low nibble to its column group
  function automatic logic [2:0] grp_of(input logic [3:0] lo);
    logic [2:0] g;
    g = 3'h7;
    if (lo < 4'h6)
      g = lo[2:0];
    else if (lo < 4'h8)
      g = 3'h6;
    return g;
  endfunction : grp_of

  logic [7:0]  ent;
  logic [3:0]  cyc_taken;
  logic        is_cond;
  logic        accept;
  logic        is_xwr;
  logic        is_xrd;
  logic        is_ri;
  logic [15:0] rel_ext;

  // Decode the opcode through the timing table (one lookup, every opcode)
  always_comb
  begin
    // One entry per column group and high nibble
    ent       = ECT_TBL[grp_of(i_opcode[3:0])][i_opcode[7:4]];
    cyc_taken = ent[ECT_F_CYC_H:ECT_F_CYC_L];
    is_cond   = ent[ECT_F_COND];
    is_ri     = (i_opcode[7:1] == ECT_OP_XRD_RI) ||
                (i_opcode[7:1] == ECT_OP_XWR_RI);
    is_xrd    = (i_opcode == ECT_OP_XRD_DP) ||
                (i_opcode[7:1] == ECT_OP_XRD_RI);
    is_xwr    = (i_opcode == ECT_OP_XWR_DP) ||
                (i_opcode[7:1] == ECT_OP_XWR_RI);
    rel_ext   = {{8{i_rel[7]}}, i_rel};
    accept    = i_issue && st.ready;
  end

  // Next state: load on issue, else count down in plain clock cycles
  always_comb
  begin
    next_st      = st;
    next_st.xrd  = 1'b0;
    next_st.xwr  = 1'b0;
    next_st.fwr  = 1'b0;
    next_st.fer  = 1'b0;
    next_st.crd  = 1'b0;
    if (accept)
    begin
      next_st.len  = ent[ECT_F_LEN_H:ECT_F_LEN_L];
      next_st.cond = is_cond;
      // Untaken branch skips the refetch cycle
      if (is_cond && !i_taken)
        next_st.cyc = cyc_taken - 4'h1;
      else
        next_st.cyc = cyc_taken;
      next_st.cnt     = next_st.cyc;
      next_st.target  = i_pc_next + rel_ext;
      next_st.dir_sfr = (i_direct >= ECT_SFR_BASE);
      next_st.addr    = ECT_ADDR_RST;
      // Code reads use accumulator plus pointer or next PC
      if (i_opcode == ECT_OP_CODE_DP)
      begin
        next_st.crd  = 1'b1;
        next_st.addr = i_data_pointer_16 + {8'h00, i_acc};
      end
      else if (i_opcode == ECT_OP_CODE_PC)
      begin
        next_st.crd  = 1'b1;
        next_st.addr = i_pc_next + {8'h00, i_acc};
      end
      else if (is_xrd || is_xwr)
        next_st.addr = is_ri ? {8'h00, i_ri} : i_data_pointer_16;
      next_st.xrd = is_xrd;
      // Writes go to flash when the flash controller has armed it
      if (is_xwr && i_flash_wr_en)
      begin
        next_st.fwr = !i_flash_erase;
        next_st.fer = i_flash_erase;
      end
      else
        next_st.xwr = is_xwr;
    end
    else if (st.cnt != ECT_CNT_RST)
      next_st.cnt = st.cnt - 4'h1;
    // Ready from the last busy cycle on, so one-cycle ops run back to back
    next_st.ready = (next_st.cnt <= 4'h1);
    next_st.done  = (next_st.cnt == 4'h1);
    // Registered so the busy output needs no gate after the flop
    next_st.busy  = (next_st.cnt != ECT_CNT_RST);
  end

  // State register with synchronous reset
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      st       <= '0;
      st.cnt   <= ECT_CNT_RST;
      st.len   <= ECT_LEN_RST;
      st.addr  <= ECT_ADDR_RST;
      st.ready <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Every output straight from the state register
  assign o_ready       = st.ready;
  assign o_busy        = st.busy;
  assign o_done        = st.done;
  assign o_len         = st.len;
  assign o_cycles      = st.cyc;
  assign o_cond        = st.cond;
  assign o_external_data_space_rd    = st.xrd;
  assign o_external_data_space_wr    = st.xwr;
  assign o_flash_wr    = st.fwr;
  assign o_flash_erase = st.fer;
  assign o_code_rd     = st.crd;
  assign o_addr        = st.addr;
  assign o_target      = st.target;
  assign o_dir_sfr     = st.dir_sfr;

endmodule : ect_core_timing

// ===== hdl/ect_pkg.sv
package ect_pkg;

  // Decode entry: [7] conditional branch, [5:4] bytes, [3:0] taken cycles
  localparam int ECT_F_COND  = 7;
  localparam int ECT_F_LEN_H = 5;
  localparam int ECT_F_LEN_L = 4;
  localparam int ECT_F_CYC_H = 3;
  localparam int ECT_F_CYC_L = 0;

  // Low-nibble column groups of the opcode map
  localparam int ECT_NGRP = 8;

  // Entries per group, indexed by the opcode high nibble
  localparam logic [7:0] ECT_TBL [ECT_NGRP][16] = '{
    // x0: misc, bit branches, pointer load, stack, data_pointer_16 external moves
    '{8'h11, 8'hb4, 8'hb4, 8'hb4, 8'ha3, 8'ha3, 8'ha3, 8'ha3,
      8'h23, 8'h33, 8'h22, 8'h22, 8'h22, 8'h22, 8'h13, 8'h13},
    // x1: absolute jump and call
    '{8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23,
      8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23, 8'h23},
    // x2: long jump/call, returns, logic into direct, bit ops, R0 moves
    '{8'h34, 8'h34, 8'h15, 8'h15, 8'h22, 8'h22, 8'h22, 8'h22,
      8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h13, 8'h13},
    // x3: rotates, logic immediate into direct, code reads, R1 moves
    '{8'h11, 8'h11, 8'h11, 8'h11, 8'h33, 8'h33, 8'h33, 8'h13,
      8'h13, 8'h13, 8'h11, 8'h11, 8'h11, 8'h11, 8'h13, 8'h13},
    // x4: accumulator and immediate operations
    '{8'h11, 8'h11, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22,
      8'h18, 8'h22, 8'h14, 8'hb4, 8'h11, 8'h11, 8'h11, 8'h12},
    // x5: direct operand; column A is the spare opcode, run as no-op
    '{8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h22, 8'h33,
      8'h33, 8'h22, 8'h11, 8'hb5, 8'h22, 8'hb4, 8'h22, 8'h22},
    // x6/x7: indirect RAM operand
    '{8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h12, 8'h22,
      8'h22, 8'h12, 8'h22, 8'hb5, 8'h12, 8'h12, 8'h12, 8'h12},
    // x8..xF: bank register operand
    '{8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h11, 8'h22,
      8'h22, 8'h11, 8'h22, 8'hb4, 8'h11, 8'ha3, 8'h11, 8'h11}
  };

  // Opcodes with side effects toward memories, plus the spare opcode
  localparam logic [7:0] ECT_OP_SPARE    = 8'ha5;
  localparam logic [7:0] ECT_OP_CODE_DP  = 8'h93;
  localparam logic [7:0] ECT_OP_CODE_PC  = 8'h83;
  localparam logic [7:0] ECT_OP_XRD_DP   = 8'he0;
  localparam logic [7:0] ECT_OP_XWR_DP   = 8'hf0;
  localparam logic [6:0] ECT_OP_XRD_RI   = 7'h71; // e2/e3
  localparam logic [6:0] ECT_OP_XWR_RI   = 7'h79; // f2/f3

  // Direct addresses at or above this select the special register space
  localparam logic [7:0] ECT_SFR_BASE    = 8'h80;

  // Reset values
  localparam logic [3:0]  ECT_CNT_RST    = 4'h0;
  localparam logic [15:0] ECT_ADDR_RST   = 16'h0000;
  localparam logic [1:0]  ECT_LEN_RST    = 2'h0;

  typedef struct packed {
    logic [3:0]  cnt;       // Cycles left of current instruction
    logic        ready;     // Next instruction may issue
    logic        done;      // Last execution cycle
    logic [1:0]  len;       // Program bytes of current instruction
    logic [3:0]  cyc;       // Cycles charged to current instruction
    logic        cond;      // Current instruction is a conditional branch
    logic        xrd;       // External data read strobe
    logic        xwr;       // External data write strobe
    logic        fwr;       // Flash program write strobe
    logic        fer;       // Flash erase strobe
    logic        crd;       // Code byte read strobe
    logic [15:0] addr;      // Memory address for the strobes
    logic [15:0] target;    // Relative branch destination
    logic        dir_sfr;   // Direct operand lands in register space
    logic        busy;      // Execution cycles still running
  } ect_state_t;

endpackage : ect_pkg

// ===== sim/ect_core_timing_assertions.sv
`timescale 1ns/1ps

module ect_chk
  import ect_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_issue,
  input wire logic [7:0]  i_opcode,
  input wire logic        i_taken,
  input wire logic [15:0] i_pc_next,
  input wire logic [7:0]  i_rel,
  input wire logic [7:0]  i_direct,
  input wire logic        i_flash_wr_en,
  input wire logic        i_flash_erase,
  input wire logic        o_ready,
  input wire logic        o_busy,
  input wire logic        o_done,
  input wire logic [3:0]  o_cycles,
  input wire logic        o_external_data_space_wr,
  input wire logic        o_flash_wr,
  input wire logic [15:0] o_target,
  input wire logic        o_dir_sfr
);
  logic        tk;
  logic [15:0] rel_x;
  // Accepted issue and sign-extended offset
  assign tk = i_issue && o_ready;
  assign rel_x = {{8{i_rel[7]}}, i_rel};

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  issue_starts_a: assert property (tk |=> o_busy)
    else $error("accepted issue did not start");
  busy_blocks_a: assert property (o_busy && !o_done |-> !o_ready)
    else $error("ready raised before count ran out");
  mul_four_a: assert property (tk && i_opcode == 8'ha4 |=>
    (o_cycles == 4'h4 && !o_done)[*3] ##1 o_done)
    else $error("multiply not four cycles");
  div_eight_a: assert property (tk && i_opcode == 8'h84 |=>
    o_cycles == 4'h8) else $error("divide not eight cycles");
  untaken_less_a: assert property (tk && i_opcode == 8'h60 |=>
    o_cycles == ($past(i_taken) ? 4'h3 : 4'h2))
    else $error("branch count wrong");
  flash_route_a: assert property (tk && i_opcode == 8'hf0
    && i_flash_wr_en |=> !o_external_data_space_wr && o_flash_wr == !$past(i_flash_erase))
    else $error("flash write misrouted");
  spare_nop_a: assert property (tk && i_opcode == 8'ha5 |=>
    o_cycles == 4'h1 && o_done) else $error("spare opcode not a no-op");
  branch_target_a: assert property (tk |=>
    o_target == $past(i_pc_next) + $past(rel_x))
    else $error("relative target wrong");
  sfr_split_a: assert property (tk |=>
    o_dir_sfr == ($past(i_direct) >= 8'h80))
    else $error("direct space split wrong");

  cover property (tk && i_opcode == 8'ha4);
  cover property (o_flash_wr);
  cover property (tk && i_opcode == 8'h60 && !i_taken);
endmodule : ect_chk

bind ect_core_timing ect_chk u_chk (.i_mclk, .i_rst, .i_issue, .i_opcode,
  .i_taken, .i_pc_next, .i_rel, .i_direct, .i_flash_wr_en, .i_flash_erase,
  .o_ready, .o_busy, .o_done, .o_cycles, .o_external_data_space_wr, .o_flash_wr,
  .o_target, .o_dir_sfr);

// ===== sim/ect_core_timing_bench.sv
`timescale 1ns/1ps

module ect_core_timing_bench
  import ect_pkg::*;
();
  logic        i_mclk = 1'b0, i_rst = 1'b1, i_issue = 1'b0, i_taken = 1'b0;
  logic        i_flash_wr_en = 1'b0, i_flash_erase = 1'b0, clr = 1'b1;
  logic [7:0]  i_opcode = 8'h00, i_rel = 8'h00, i_direct = 8'h00;
  logic [7:0]  i_acc = 8'h00, i_ri = 8'h00;
  logic [15:0] i_pc_next = 16'h0000, i_data_pointer_16 = 16'h0000;
  logic        o_ready, o_busy, o_done, o_cond, o_dir_sfr, o_code_rd;
  logic        o_external_data_space_rd, o_external_data_space_wr, o_flash_wr, o_flash_erase;
  logic [1:0]  o_len;
  logic [3:0]  o_cycles;
  logic [15:0] o_addr, o_target;
  logic [19:0] hits;
  int          num_errors = 0, checks_done = 0;

  // 40 MHz clock
  always #12.5 i_mclk = ~i_mclk;

  ect_core_timing dut (.i_mclk, .i_rst, .i_issue, .i_opcode, .i_taken,
    .i_pc_next, .i_rel, .i_direct, .i_acc, .i_ri, .i_data_pointer_16, .i_flash_wr_en,
    .i_flash_erase, .o_ready, .o_busy, .o_done, .o_len, .o_cycles, .o_cond,
    .o_external_data_space_rd, .o_external_data_space_wr, .o_flash_wr, .o_flash_erase, .o_code_rd,
    .o_addr, .o_target, .o_dir_sfr);
  ect_mem_model mem (.i_mclk, .i_clear(clr), .o_cnt(hits), .i_strobe(
    {o_external_data_space_rd, o_external_data_space_wr, o_flash_wr, o_flash_erase, o_code_rd}));

  task automatic chk(input string nm, input logic [19:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic tally_and_finish;
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  // One instruction: lc is {bytes, cycles}, h the expected strobe counts
  task automatic exe(input logic [7:0] op, input logic tk,
                     input logic [7:0] lc, input logic [19:0] h);
    int n;
    @(negedge i_mclk);
    i_opcode = op;
    i_taken = tk;
    i_issue = 1'b1;
    clr = 1'b1;
    @(negedge i_mclk);
    i_issue = 1'b0;
    clr = 1'b0;
    chk("len", lc[5:4], o_len);
    chk("cycles", lc[3:0], o_cycles);
    for (n = 1; o_done !== 1'b1 && n < 12; n++)
      @(negedge i_mclk);
    chk("done", lc[3:0], n[3:0]);
    if (n == 12)
      tally_and_finish();
    @(negedge i_mclk);
    chk("hits", h, hits);
  endtask : exe

  task automatic s_arith;
    logic [15:0] t [13] = '{16'h2811, 16'h2522, 16'h2612, 16'h2422,
      16'h3522, 16'h9612, 16'h0411, 16'h0522, 16'h0612, 16'ha311,
      16'ha414, 16'h8418, 16'hd411};
    foreach (t[k]) exe(t[k][15:8], 1'b0, t[k][7:0], 20'h0);
  endtask : s_arith

  task automatic s_logic;
    logic [15:0] t [9] = '{16'h5811, 16'h4612, 16'h6222, 16'h5333,
      16'he411, 16'hf412, 16'h2311, 16'h1311, 16'hc411};
    foreach (t[k]) exe(t[k][15:8], 1'b0, t[k][7:0], 20'h0);
  endtask : s_logic

  task automatic s_move;
    logic [15:0] t [15] = '{16'h8533, 16'h7533, 16'hf612, 16'ha622,
      16'h7622, 16'h8622, 16'h9033, 16'hc022, 16'hd022, 16'hc811,
      16'hc522, 16'hc612, 16'hd612, 16'h0011, 16'ha511};
    foreach (t[k]) exe(t[k][15:8], 1'b0, t[k][7:0], '0);
  endtask : s_move

  // Taken and untaken branch, backward offset, both direct spaces
  task automatic s_branch;
    i_pc_next = 16'h1000;
    i_rel = 8'hfe;
    i_direct = 8'h80;
    exe(8'h60, 1'b1, 8'h23, 20'h0);
    chk("target", 16'h0ffe, o_target);
    chk("sfr", 1'b1, o_dir_sfr);
    chk("cond", 1'b1, o_cond);
    i_direct = 8'h7f;
    exe(8'h40, 1'b0, 8'h22, 20'h0);
    chk("sfr", 1'b0, o_dir_sfr);
    exe(8'h00, 1'b0, 8'h11, 20'h0);
    chk("cond", 1'b0, o_cond);
  endtask : s_branch

  // Code reads, external data and flash program or erase
  task automatic s_xmem;
    i_acc = 8'h10;
    i_data_pointer_16 = 16'h1234;
    i_ri = 8'h5a;
    i_pc_next = 16'h2000;
    exe(8'h93, 1'b0, 8'h13, 20'h00001);
    chk("addr", 16'h1244, o_addr);
    exe(8'h83, 1'b0, 8'h13, 20'h00001);
    chk("addr", 16'h2010, o_addr);
    exe(8'hf3, 1'b0, 8'h13, 20'h01000);
    chk("addr", 16'h005a, o_addr);
    exe(8'he0, 1'b0, 8'h13, 20'h10000);
    chk("addr", 16'h1234, o_addr);
    i_flash_wr_en = 1'b1;
    exe(8'hf0, 1'b0, 8'h13, 20'h00100);
    i_flash_erase = 1'b1;
    exe(8'hf0, 1'b0, 8'h13, 20'h00010);
    i_flash_wr_en = 1'b0;
    i_flash_erase = 1'b0;
  endtask : s_xmem

  // Issue held high through a multiply: refused until its count ends
  task automatic s_refuse;
    @(negedge i_mclk);
    i_opcode = 8'ha4;
    i_issue = 1'b1;
    @(negedge i_mclk);
    i_opcode = 8'h84;
    repeat (4) @(negedge i_mclk);
    chk("cycles", 4'h8, o_cycles);
    i_issue = 1'b0;
    repeat (8) @(negedge i_mclk);
  endtask : s_refuse

  initial
  begin
    repeat (4) @(negedge i_mclk);
    i_rst = 1'b0;
    chk("ready", 1'b1, o_ready);
    s_arith();
    s_logic();
    s_move();
    s_branch();
    s_xmem();
    s_refuse();
    tally_and_finish();
  end
endmodule : ect_core_timing_bench

// ===== sim/ect_mem_model.sv
`timescale 1ns/1ps

// Far-side memory stand-in: counts every access strobe per kind
module ect_mem_model
  import ect_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_clear,
  input  wire logic [4:0]  i_strobe,
  output logic      [19:0] o_cnt
);
  // Counting, not latching, so a strobe held two cycles shows up
  always_ff @(posedge i_mclk)
  begin
    for (int k = 0; k < 5; k++)
    begin
      o_cnt[4*k +: 4] <= i_clear ? 4'h0
                       : o_cnt[4*k +: 4] + {3'h0, i_strobe[k]};
    end
  end
endmodule : ect_mem_model
